/* bench/dac_host_model.sv */
// Host serial port model driving the DAC serial link
`timescale 1ns/100ps
module dac_host_model (
    // Serial link
    output logic serial_clk,
    output logic frame_sync_n,
    output logic serial_in
);
    initial
    begin
        serial_clk = 1'b0;
        frame_sync_n = 1'b1;
        serial_in = 1'b0;
    end
    // Clock runs only inside a frame; optional pause after each byte
    task automatic send(input logic [31:0] bits, input int n, input bit burst);
        // Start away from the system clock edge
        #7 frame_sync_n = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--)
        begin
            #3.75 serial_in = bits[i];
            #3.75 serial_clk = 1'b1;
            #7.5 serial_clk = 1'b0;
            if (burst && i % 8 == 0)
                #40;
        end
        #10 frame_sync_n = 1'b1;
        serial_in = ~serial_in;
    endtask
endmodule

/* bench/dac_serial_load_control_bench.sv */
// Self-checking bench of the serial DAC loading block
`timescale 1ns/100ps
module dac_serial_load_control_bench;
    localparam int DATA_BITS = 16;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic chain_select = 1'b0;
    logic latch_load_n = 1'b0;
    logic clear_n = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic serial_clk, frame_sync_n, serial_in, serial_out;
    logic [15:0] latch_code;
    logic [DATA_BITS-1:0] dac_code;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    always #50 aclk = ~aclk;
    dac_host_model host (.serial_clk(serial_clk), .frame_sync_n(frame_sync_n), .serial_in(serial_in));
    dac_serial_load_control #(.DATA_BITS(DATA_BITS)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .serial_clk(serial_clk), .frame_sync_n(frame_sync_n), .serial_in(serial_in),
        .serial_out(serial_out), .chain_select(chain_select), .latch_load_n(latch_load_n),
        .clear_n(clear_n), .latch_code(latch_code), .dac_code(dac_code));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed);
        check({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic strobe();
        @(posedge aclk);
        latch_load_n <= 1'b0;
        wait_clk(8);
        latch_load_n <= 1'b1;
    endtask
    task automatic t_regs();
        axi_read(dac_serial_pkg::CTRL_OFFSET, dac_serial_pkg::CTRL_RESET, dac_serial_pkg::RESP_OKAY);
        axi_read(dac_serial_pkg::LATCH_OFFSET, 32'h0, dac_serial_pkg::RESP_OKAY);
        axi_read(8'h20, 32'h0, dac_serial_pkg::RESP_SLVERR);
        axi_write(8'h20, 32'hFFFF_FFFF, dac_serial_pkg::RESP_SLVERR);
        $display("test regs done");
    endtask
    task automatic t_auto();
        host.send(32'h000A_5C3F, 20, 1'b0);
        wait_clk(10);
        check({16'h0, latch_code}, 32'h0000_A5C3);
        check({16'h0, dac_code}, 32'h0000_A5C3);
        axi_read(dac_serial_pkg::INPUT_OFFSET, 32'h0000_A5C3, dac_serial_pkg::RESP_OKAY);
        host.send(32'h0000_3C5A, 16, 1'b1);
        wait_clk(10);
        check({16'h0, latch_code}, 32'h0000_3C5A);
        axi_read(dac_serial_pkg::STATUS_OFFSET, 32'h1 << dac_serial_pkg::STATUS_AUTO_BIT,
            dac_serial_pkg::RESP_OKAY);
        $display("test auto done");
    endtask
    task automatic t_strobed();
        @(posedge aclk);
        latch_load_n <= 1'b1;
        wait_clk(4);
        host.send(32'h0000_1234, 16, 1'b0);
        wait_clk(10);
        check({16'h0, latch_code}, 32'h0000_3C5A);
        strobe();
        check({16'h0, latch_code}, 32'h0000_1234);
        check({16'h0, dac_code}, 32'h0000_3C5A);
        axi_read(dac_serial_pkg::STATUS_OFFSET, 32'h1 << dac_serial_pkg::STATUS_HOLD_BIT,
            dac_serial_pkg::RESP_OKAY);
        axi_read(dac_serial_pkg::OUTPUT_OFFSET, 32'h0000_3C5A, dac_serial_pkg::RESP_OKAY);
        wait_clk(60);
        check({16'h0, dac_code}, 32'h0000_1234);
        $display("test strobed done");
    endtask
    task automatic t_chain();
        @(posedge aclk);
        chain_select <= 1'b1;
        wait_clk(4);
        host.send(32'h0000_5555, 16, 1'b0);
        wait_clk(10);
        host.send(32'hBEEF_0F0F, 32, 1'b0);
        wait_clk(10);
        check({16'h0, latch_code}, 32'h0000_1234);
        axi_read(dac_serial_pkg::STATUS_OFFSET, 32'h1 << dac_serial_pkg::STATUS_CHAIN_BIT,
            dac_serial_pkg::RESP_OKAY);
        strobe();
        check({16'h0, latch_code}, 32'h0000_0F0F);
        wait_clk(60);
        check({16'h0, dac_code}, 32'h0000_0F0F);
        chain_select <= 1'b0;
        wait_clk(4);
        host.send(32'h0000_0000, 16, 1'b0);
        $display("test chain done");
    endtask
    task automatic t_clear();
        @(posedge aclk);
        clear_n <= 1'b0;
        wait_clk(8);
        check({16'h0, latch_code}, 32'h0);
        check({16'h0, dac_code}, 32'h0);
        clear_n <= 1'b1;
        latch_load_n <= 1'b0;
        wait_clk(60);
        check({16'h0, latch_code}, 32'h0);
        host.send(32'h0000_7E81, 16, 1'b0);
        wait_clk(10);
        check({16'h0, latch_code}, 32'h0000_7E81);
        axi_write(dac_serial_pkg::CTRL_OFFSET, 32'h1, dac_serial_pkg::RESP_OKAY);
        wait_clk(6);
        check({16'h0, latch_code}, 32'h0);
        axi_write(dac_serial_pkg::CTRL_OFFSET, 32'h0, dac_serial_pkg::RESP_OKAY);
        axi_read(dac_serial_pkg::LATCH_OFFSET, 32'h0, dac_serial_pkg::RESP_OKAY);
        $display("test clear done");
    endtask
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    initial
    begin
        wait_clk(16);
        aresetn <= 1'b1;
        wait_clk(4);
        t_regs();
        t_auto();
        t_strobed();
        t_chain();
        t_clear();
        give_verdict();
    end
endmodule
bind dac_serial_load_control dac_serial_load_control_checker #(.DATA_BITS(DATA_BITS)) chk (
    .aclk(aclk), .aresetn(aresetn), .serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
    .serial_in(serial_in), .serial_out(serial_out), .chain_select(chain_select),
    .latch_load_n(latch_load_n), .clear_n(clear_n), .latch_code(latch_code), .dac_code(dac_code));

/* bench/dac_serial_load_control_checker.sv */
// Concurrent checks on the serial DAC loading block ports
`timescale 1ns/100ps
module dac_serial_load_control_checker #(
    parameter int DATA_BITS = 16
) (
    // System
    input wire logic aclk,
    input wire logic aresetn,
    // Link
    input wire logic serial_clk,
    input wire logic frame_sync_n,
    input wire logic serial_in,
    input wire logic serial_out,
    // Control pins
    input wire logic chain_select,
    input wire logic latch_load_n,
    input wire logic clear_n,
    // Codes
    input wire logic [15:0] latch_code,
    input wire logic [DATA_BITS-1:0] dac_code
);
    logic [5:0] hold_cnt;
    logic [4:0] edge_cnt;
    logic [16:0] hist;
    // Cycles since the strobe fell
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hold_cnt <= 6'h00;
        else if (!latch_load_n && $past(latch_load_n))
            hold_cnt <= 6'h01;
        else if (hold_cnt != 6'h00 && hold_cnt != 6'h3F)
            hold_cnt <= hold_cnt + 6'h01;
    end
    // Bits seen in the current frame
    always_ff @(negedge serial_clk or posedge frame_sync_n)
    begin
        if (frame_sync_n)
            edge_cnt <= 5'h00;
        else
        begin
            edge_cnt <= edge_cnt + {4'h0, edge_cnt != 5'h1F};
            hist <= {hist[15:0], serial_in};
        end
    end
    chk_clear_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        !clear_n [*6] |-> latch_code == 16'h0000) else $error("latch not cleared");
    chk_clear_output: assert property (@(posedge aclk) disable iff (!aresetn)
        !clear_n [*6] |-> dac_code == '0) else $error("output not cleared");
    chk_release_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(clear_n) |-> (latch_code == 16'h0000) [*4]) else $error("latch reloaded after clear");
    chk_out_from_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(dac_code) && clear_n |-> dac_code == latch_code[15 -: DATA_BITS] || dac_code == '0)
        else $error("output not from latch");
    chk_hold_stable: assert property (@(posedge aclk) disable iff (!aresetn)
        hold_cnt inside {[2:50]} && clear_n && $past(clear_n) |-> $stable(dac_code))
        else $error("output moved during hold");
    chk_hold_ends: assert property (@(posedge aclk) disable iff (!aresetn)
        hold_cnt == 6'h3C && clear_n |-> dac_code == latch_code[15 -: DATA_BITS])
        else $error("output missed latch after hold");
    chk_idle_sout: assert property (@(posedge aclk) disable iff (!aresetn)
        frame_sync_n && $past(frame_sync_n) |-> !serial_out) else $error("serial out active idle");
    chk_chain_sout: assert property (@(negedge serial_clk) disable iff (!aresetn || frame_sync_n)
        chain_select && edge_cnt >= 5'h11 |-> serial_out == hist[16]) else $error("chain bit wrong");
    cover property (@(negedge serial_clk) chain_select && edge_cnt == 5'h1F);
    cover property (@(posedge aclk) hold_cnt == 6'h3C);
    cover property (@(posedge aclk) !clear_n [*6]);
endmodule

/* rtl/dac_serial_load_control.sv */
// Serial loading, update and clear logic of the DAC with an AXI4-Lite view
`timescale 1ns/100ps
module dac_serial_load_control #(
    parameter int DATA_BITS = 16
) (
    // System clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial link
    input wire logic serial_clk,
    input wire logic frame_sync_n,
    input wire logic serial_in,
    output logic serial_out,
    // Control pins
    input wire logic chain_select,
    input wire logic latch_load_n,
    input wire logic clear_n,
    // Converter code
    output logic [15:0] latch_code,
    output logic [DATA_BITS-1:0] dac_code
);
    if (DATA_BITS != 14 && DATA_BITS != 16)
    begin : g_bad_width
        $error("DATA_BITS must be 14 or 16");
    end

    // ---------------- Link domain, falling serial clock ----------------
    logic chain_meta_reg;
    logic chain_link_reg;
    logic [4:0] bit_count_reg;
    logic [15:0] shift_reg;
    logic [15:0] word_hold_reg;
    logic word_done_tgl_reg;
    logic serial_out_reg;
    logic gate_open;

    // Chain select into the link domain
    always_ff @(negedge serial_clk or negedge aresetn)
    begin
        if (!aresetn)
        begin
            chain_meta_reg <= 1'b0;
            chain_link_reg <= 1'b0;
        end
        else
        begin
            chain_meta_reg <= chain_select;
            chain_link_reg <= chain_meta_reg;
        end
    end

    assign gate_open = chain_link_reg || (bit_count_reg < dac_serial_pkg::WORD_BITS_COUNT);

    // Bit counter, cleared while frame sync is high
    always_ff @(negedge serial_clk or negedge aresetn or posedge frame_sync_n)
    begin
        if (!aresetn)
        begin
            bit_count_reg <= 5'h00;
        end
        else if (frame_sync_n)
        begin
            bit_count_reg <= 5'h00;
        end
        else if (!chain_link_reg && gate_open)
        begin
            bit_count_reg <= bit_count_reg + 5'h01;
        end
    end

    // Shift register, MSB first
    always_ff @(negedge serial_clk or negedge aresetn)
    begin
        if (!aresetn)
        begin
            shift_reg <= 16'h0000;
        end
        else if (!frame_sync_n && gate_open)
        begin
            shift_reg <= {shift_reg[14:0], serial_in};
        end
    end

    // Completed word for automatic update
    always_ff @(negedge serial_clk or negedge aresetn)
    begin
        if (!aresetn)
        begin
            word_hold_reg <= 16'h0000;
            word_done_tgl_reg <= 1'b0;
        end
        else if (!frame_sync_n && !chain_link_reg && bit_count_reg == dac_serial_pkg::LAST_BIT_COUNT)
        begin
            word_hold_reg <= {shift_reg[14:0], serial_in};
            word_done_tgl_reg <= ~word_done_tgl_reg;
        end
    end

    // Serial output: bit leaving the top stage in chain mode, held low otherwise
    always_ff @(negedge serial_clk or negedge aresetn or posedge frame_sync_n)
    begin
        if (!aresetn)
        begin
            serial_out_reg <= 1'b0;
        end
        else if (frame_sync_n)
        begin
            serial_out_reg <= 1'b0;
        end
        else if (chain_link_reg)
        begin
            serial_out_reg <= shift_reg[15];
        end
        else
        begin
            serial_out_reg <= 1'b0;
        end
    end

    assign serial_out = serial_out_reg;

    // ---------------- System domain ----------------
    localparam int PIN_COUNT = 5;
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_meta_reg;
    logic [PIN_COUNT-1:0] pin_sync_reg;
    assign pin_raw = {chain_select, word_done_tgl_reg, clear_n, latch_load_n, frame_sync_n};

    // Two-stage synchronisers for pins and the word toggle
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++)
        begin : g_sync
            // No reset: stages follow the pins during reset
            always_ff @(posedge aclk)
            begin
                pin_meta_reg[gi] <= pin_raw[gi];
                pin_sync_reg[gi] <= pin_meta_reg[gi];
            end
        end
    endgenerate

    logic sync_s;
    logic load_s;
    logic clear_s;
    logic toggle_s;
    logic chain_s;
    assign sync_s = pin_sync_reg[0];
    assign load_s = pin_sync_reg[1];
    assign clear_s = pin_sync_reg[2];
    assign toggle_s = pin_sync_reg[3];
    assign chain_s = pin_sync_reg[4];

    logic sync_last_reg;
    logic load_last_reg;
    logic toggle_last_reg;
    // Tracks through reset too, so a low pin gives no false edge
    always_ff @(posedge aclk)
    begin
        sync_last_reg <= sync_s;
        load_last_reg <= load_s;
        toggle_last_reg <= toggle_s;
    end

    logic frame_start;
    logic load_fall;
    logic word_done;
    assign frame_start = sync_last_reg && !sync_s;
    assign load_fall = load_last_reg && !load_s;
    assign word_done = toggle_last_reg != toggle_s;

    // Update mode chosen at frame start
    logic auto_mode_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            auto_mode_reg <= 1'b0;
        end
        else if (frame_start)
        begin
            auto_mode_reg <= !load_s;
        end
    end

    // Software clear control
    logic [31:0] ctrl_reg;
    logic clear_any;
    assign clear_any = !clear_s || ctrl_reg[dac_serial_pkg::CTRL_SW_CLEAR_BIT];

    // DAC latch
    logic [15:0] latch_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            latch_reg <= dac_serial_pkg::LATCH_RESET;
        end
        else if (clear_any)
        begin
            latch_reg <= 16'h0000;
        end
        else if (load_fall)
        begin
            latch_reg <= shift_reg;
        end
        else if (word_done && auto_mode_reg)
        begin
            latch_reg <= word_hold_reg;
        end
    end

    assign latch_code = latch_reg;

    // Track-and-hold output stage
    dac_serial_pkg::out_state_t out_state_reg;
    logic [5:0] hold_count_reg;
    logic [15:0] out_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_state_reg <= dac_serial_pkg::OUT_TRACK;
            hold_count_reg <= 6'h00;
        end
        else if (clear_any)
        begin
            out_state_reg <= dac_serial_pkg::OUT_TRACK;
            hold_count_reg <= 6'h00;
        end
        else
        begin
            unique case (out_state_reg)
                dac_serial_pkg::OUT_TRACK:
                begin
                    if (load_fall)
                    begin
                        out_state_reg <= dac_serial_pkg::OUT_HOLD;
                        hold_count_reg <= 6'(dac_serial_pkg::HOLD_CYCLES - 1);
                    end
                end
                dac_serial_pkg::OUT_HOLD:
                begin
                    if (load_fall)
                    begin
                        hold_count_reg <= 6'(dac_serial_pkg::HOLD_CYCLES - 1);
                    end
                    else if (hold_count_reg == 6'h00)
                    begin
                        out_state_reg <= dac_serial_pkg::OUT_TRACK;
                    end
                    else
                    begin
                        hold_count_reg <= hold_count_reg - 6'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_reg <= dac_serial_pkg::LATCH_RESET;
        end
        else if (out_state_reg == dac_serial_pkg::OUT_TRACK && !load_fall)
        begin
            out_reg <= latch_reg;
        end
    end

    assign dac_code = out_reg[15 -: DATA_BITS];

    // ---------------- AXI4-Lite slave ----------------
    logic aw_got_reg;
    logic w_got_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = !w_got_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    logic write_go;
    assign write_go = aw_got_reg && w_got_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else if (write_go)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= dac_serial_pkg::RESP_OKAY;
        end
        else if (write_go)
        begin
            bvalid_reg <= 1'b1;
            unique case (aw_addr_reg)
                dac_serial_pkg::CTRL_OFFSET, dac_serial_pkg::STATUS_OFFSET, dac_serial_pkg::LATCH_OFFSET,
                dac_serial_pkg::OUTPUT_OFFSET, dac_serial_pkg::INPUT_OFFSET:
                begin
                    bresp_reg <= dac_serial_pkg::RESP_OKAY;
                end
                default:
                begin
                    bresp_reg <= dac_serial_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_bready)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    // Control register with byte enables
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg <= dac_serial_pkg::CTRL_RESET;
        end
        else if (write_go && aw_addr_reg == dac_serial_pkg::CTRL_OFFSET)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (w_strb_reg[b])
                begin
                    ctrl_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
                end
            end
        end
    end

    dac_serial_pkg::status_t status;
    assign status.chain_mode = chain_s;
    assign status.frame_active = !sync_s;
    assign status.hold_busy = out_state_reg == dac_serial_pkg::OUT_HOLD;
    assign status.auto_mode = auto_mode_reg;

    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= dac_serial_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg <= dac_serial_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                dac_serial_pkg::CTRL_OFFSET: rdata_reg <= ctrl_reg;
                dac_serial_pkg::STATUS_OFFSET: rdata_reg <= {28'h0000000, status};
                dac_serial_pkg::LATCH_OFFSET: rdata_reg <= {16'h0000, latch_reg};
                dac_serial_pkg::OUTPUT_OFFSET: rdata_reg <= {16'h0000, out_reg};
                dac_serial_pkg::INPUT_OFFSET: rdata_reg <= {16'h0000, word_hold_reg};
                default:
                begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= dac_serial_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule

/* shared/dac_serial_pkg.sv */
// Constants and types shared by the serial DAC loading block
package dac_serial_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] LATCH_OFFSET = 8'h08;
    localparam logic [7:0] OUTPUT_OFFSET = 8'h0C;
    localparam logic [7:0] INPUT_OFFSET = 8'h10;
    // Field positions
    localparam int CTRL_SW_CLEAR_BIT = 0;
    localparam int STATUS_AUTO_BIT = 0;
    localparam int STATUS_HOLD_BIT = 1;
    localparam int STATUS_FRAME_BIT = 2;
    localparam int STATUS_CHAIN_BIT = 3;
    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    // Serial word
    localparam int WORD_BITS = 16;
    localparam logic [4:0] WORD_BITS_COUNT = 5'h10;
    localparam logic [4:0] LAST_BIT_COUNT = 5'h0F;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int HOLD_TIME_NS = 5000;
    localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic chain_mode;
        logic frame_active;
        logic hold_busy;
        logic auto_mode;
    } status_t;

    typedef enum logic [1:0] {
        OUT_TRACK = 2'b01,
        OUT_HOLD = 2'b10
    } out_state_t;
endpackage
